// >>> src/drs_map.vh
// register offsets, field positions, reset values and boot codes of the reset sequencer
`ifndef DRS_MAP_VH
`define DRS_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DRS_OFF_CRC 8'h00
`define DRS_OFF_CRS 8'h04
`define DRS_OFF_PRC 8'h08
`define DRS_OFF_DCF 8'h0c
`define DRS_OFF_CAU 8'h10
`define DRS_OFF_DCS 8'h14
`define DRS_OFF_BOOT 8'h18

// ----------------------------------------
// control_reset_config fields
// ----------------------------------------
`define DRS_CRC_CTL_REQ 0
`define DRS_CRC_ABUS_RST 1
`define DRS_CRC_PROP_EN 2
`define DRS_CRC_RELEASE 3
`define DRS_CRC_W 4
`define DRS_CRC_RST 4'h0

// ----------------------------------------
// reset_cause fields
// ----------------------------------------
`define DRS_CAU_EXT 0
`define DRS_CAU_POR 1
`define DRS_CAU_WD0 2
`define DRS_CAU_WD1 3
`define DRS_CAU_SW 4
`define DRS_CAU_W 5

// ----------------------------------------
// reset values of the wide registers
// ----------------------------------------
`define DRS_PRC_RST 32'h00000000
`define DRS_DCF_RST 32'hffffffff

// ----------------------------------------
// boot codes
// ----------------------------------------
`define DRS_BOOT_PAR 4'h0
`define DRS_BOOT_RAM 4'h1
`define DRS_BOOT_SER 4'h2
`define DRS_BOOT_CAN 4'h3
`define DRS_BOOT_ENET 4'h4
`define DRS_BOOT_FLASH 4'h7
`define DRS_BOOT_SPIM 4'h9
`define DRS_BOOT_I2CM 4'ha
`define DRS_BOOT_FAST 4'hf

// ----------------------------------------
// timing
// ----------------------------------------
`define DRS_CLK_MHZ 50
`define DRS_FAST_OSC_MAX_MHZ 30

`endif

// >>> src/drs_seq.v
// reset combiner, reset release synchronisers, register port and boot sequencer
//
// Summary of operation
// - power-on or master system reset resets master cpu and interrupt controller
// - master system reset from pin, watchdogs, software or debugger request
// - watchdog reset when either master watchdog or nmi watchdog times out
// - master system reset reaches all master peripherals and subsystem
// - control cpu reset from pin, nmi watchdog, sw, debugger, request bit
// - software and debugger resets reach control side only when enabled
// - selective control-reset bit resets control subsystem on its own
// - analog bus reset bit resets analog bus and analog subsystem
// - status bit shows control system reset is active
// - peripheral reset bits act only for peripherals enabled in config
// - reset cause register reports pin, power-on, watchdog 0/1, software
// - control cpu reset drives control system reset
// - control side reads analog bus reset and pin state
// - shared reset resets analog and shared resources; bus reset and pin too
// - shared reset from pin, and enabled software or debugger request
// - external parallel port reset by master system reset only
// - control and analog held in reset until master releases them
// - boot order: init, release control and analog, then sample pins
// - control cpu idles after init until wake interrupt
// - boot pins decoded msb first into the listed boot sources
// - unsupported codes fall back to flash; code 15 is flash too
// - code 15 uses fast flash power-up, only with oscillator up to 30 MHz
//
// The implementer's own choices: the address map and the strobed register port.
`include "drs_map.vh"
`timescale 1ns/10ps
`default_nettype none

module drs_seq #(
    parameter OSC_MHZ = 25
) (
    input wire clk,
    input wire resetn,
    input wire external_reset_pin_n,
    input wire analog_reset_pin_n,
    input wire master_wdog0_timeout,
    input wire master_wdog1_timeout,
    input wire master_nmi_wdog_timeout,
    input wire control_nmi_watchdog_reset,
    input wire master_software_reset,
    input wire master_debugger_reset,
    input wire control_init_done,
    input wire master_to_control_wake_irq,
    input wire [3:0] boot_pins,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output wire master_system_reset_n,
    output wire master_cpu_reset_n,
    output wire external_parallel_port_reset_n,
    output wire control_cpu_reset_in_n,
    output wire control_system_reset_n,
    output wire shared_resource_reset_n,
    output wire analog_reset_n,
    output wire analog_bus_reset_n,
    output wire [31:0] master_periph_reset_n,
    output reg [3:0] boot_mode,
    output reg boot_mode_valid,
    output reg flash_fast_mode,
    output reg control_idle
);

// ----------------------------------------
// constants and functions
// ----------------------------------------
localparam NRST = 40;
localparam [3:0] ST_HOLD = 4'h1;
localparam [3:0] ST_WAIT = 4'h2;
localparam [3:0] ST_SAMP = 4'h4;
localparam [3:0] ST_DONE = 4'h8;

// fast flash power-up is unsafe above the oscillator limit
localparam FAST_OK = (OSC_MHZ <= `DRS_FAST_OSC_MAX_MHZ);

function [3:0] boot_decode;
    input [3:0] code;
    begin
        case (code)
            `DRS_BOOT_PAR, `DRS_BOOT_RAM, `DRS_BOOT_SER, `DRS_BOOT_CAN,
            `DRS_BOOT_ENET, `DRS_BOOT_FLASH, `DRS_BOOT_SPIM,
            `DRS_BOOT_I2CM: begin
                boot_decode = code;
            end
            `DRS_BOOT_FAST: begin
                boot_decode = FAST_OK ? code : `DRS_BOOT_FLASH;
            end
            default: begin
                boot_decode = `DRS_BOOT_FLASH;
            end
        endcase
    end
endfunction

function sel;
    input [7:0] a;
    input [7:0] off;
    begin
        sel = (a == off);
    end
endfunction

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
reg [5:0] pin_s1_r;
reg [5:0] pin_s2_r;

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        pin_s1_r <= 6'h3f;
        pin_s2_r <= 6'h3f;
    end else begin
        pin_s1_r <= {external_reset_pin_n, analog_reset_pin_n, boot_pins};
        pin_s2_r <= pin_s1_r;
    end
end

wire ext_low = ~pin_s2_r[5];
wire ars_low = ~pin_s2_r[4];
wire [3:0] boot_pins_s = pin_s2_r[3:0];

// ----------------------------------------
// registers
// ----------------------------------------
reg [`DRS_CRC_W-1:0] crc_r;
reg [31:0] prc_r;
reg [31:0] dcf_r;
reg [`DRS_CAU_W-1:0] cause_r;
reg [`DRS_CAU_W-1:0] cause_nxt;
reg por_seen_r;
reg [3:0] state_r;
reg [3:0] state_nxt;
reg [3:0] boot_raw_r;

wire [NRST-1:0] rst_q;
wire sys_active = ~rst_q[0];

// ----------------------------------------
// reset requests
// ----------------------------------------
wire wdog_req = master_wdog0_timeout | master_wdog1_timeout |
                master_nmi_wdog_timeout;
wire sys_req = ext_low | wdog_req | master_software_reset |
               master_debugger_reset;
wire prop_req = crc_r[`DRS_CRC_PROP_EN] &
                (master_software_reset | master_debugger_reset);
wire hold = ~crc_r[`DRS_CRC_RELEASE];
wire ctl_req = ext_low | control_nmi_watchdog_reset | prop_req |
               crc_r[`DRS_CRC_CTL_REQ] | hold;
wire shr_req = ext_low | prop_req;
wire abus_req = crc_r[`DRS_CRC_ABUS_RST] | hold;
wire ana_req = ~rst_q[5] | ~rst_q[7] | ars_low | hold;

reg [NRST-1:0] req;
integer k;

always @* begin
    req = {NRST{1'b0}};
    req[0] = sys_req;
    req[1] = sys_req;
    req[2] = sys_req;
    req[3] = ctl_req;
    req[4] = ~rst_q[3];
    req[5] = shr_req;
    req[6] = ana_req;
    req[7] = abus_req;
    for (k = 0; k < 32; k = k + 1) begin
        req[8+k] = sys_req | (prc_r[k] & dcf_r[k]);
    end
end

// ----------------------------------------
// reset release synchronisers
// ----------------------------------------
// requests come from synchronised or same-clock logic, so assertion at
// the next edge is safe; release always takes two clean edges
genvar g;
generate
    for (g = 0; g < NRST; g = g + 1) begin : g_rst
        reg st1_r;
        reg st2_r;
        always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                st1_r <= 1'b0;
                st2_r <= 1'b0;
            end else if (req[g]) begin
                st1_r <= 1'b0;
                st2_r <= 1'b0;
            end else begin
                st1_r <= 1'b1;
                st2_r <= st1_r;
            end
        end
        assign rst_q[g] = st2_r;
    end
endgenerate

assign master_system_reset_n = rst_q[0];
assign master_cpu_reset_n = rst_q[1];
assign external_parallel_port_reset_n = rst_q[2];
assign control_cpu_reset_in_n = rst_q[3];
assign control_system_reset_n = rst_q[4];
assign shared_resource_reset_n = rst_q[5];
assign analog_reset_n = rst_q[6];
assign analog_bus_reset_n = rst_q[7];
assign master_periph_reset_n = rst_q[NRST-1:8];

// ----------------------------------------
// register writes
// ----------------------------------------
always @* begin
    cause_nxt = cause_r;
    if (reg_wr && sel(reg_addr, `DRS_OFF_CAU)) begin
        cause_nxt = cause_r & ~reg_wdata[`DRS_CAU_W-1:0];
    end
    // a cause that fires during the clear survives it
    if (ext_low) begin
        cause_nxt[`DRS_CAU_EXT] = 1'b1;
    end
    if (!por_seen_r) begin
        cause_nxt[`DRS_CAU_POR] = 1'b1;
    end
    if (master_wdog0_timeout) begin
        cause_nxt[`DRS_CAU_WD0] = 1'b1;
    end
    if (master_wdog1_timeout) begin
        cause_nxt[`DRS_CAU_WD1] = 1'b1;
    end
    if (master_software_reset) begin
        cause_nxt[`DRS_CAU_SW] = 1'b1;
    end
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        crc_r <= `DRS_CRC_RST;
        prc_r <= `DRS_PRC_RST;
        dcf_r <= `DRS_DCF_RST;
        cause_r <= {`DRS_CAU_W{1'b0}};
        por_seen_r <= 1'b0;
    end else begin
        cause_r <= cause_nxt;
        por_seen_r <= 1'b1;
        if (sys_active) begin
            // master reset brings back the hold on control and analog
            crc_r <= `DRS_CRC_RST;
            prc_r <= `DRS_PRC_RST;
        end else if (reg_wr) begin
            if (sel(reg_addr, `DRS_OFF_CRC)) begin
                crc_r <= reg_wdata[`DRS_CRC_W-1:0];
            end
            if (sel(reg_addr, `DRS_OFF_PRC)) begin
                prc_r <= reg_wdata;
            end
            if (sel(reg_addr, `DRS_OFF_DCF)) begin
                dcf_r <= reg_wdata;
            end
        end
    end
end

// ----------------------------------------
// register reads
// ----------------------------------------
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
        case (reg_addr)
            `DRS_OFF_CRC: begin
                reg_rdata <= {28'h0000000, crc_r};
            end
            `DRS_OFF_CRS: begin
                reg_rdata <= {29'h00000000, ~rst_q[6], ~rst_q[3],
                              ~rst_q[4]};
            end
            `DRS_OFF_PRC: begin
                reg_rdata <= prc_r;
            end
            `DRS_OFF_DCF: begin
                reg_rdata <= dcf_r;
            end
            `DRS_OFF_CAU: begin
                reg_rdata <= {27'h0000000, cause_r};
            end
            `DRS_OFF_DCS: begin
                reg_rdata <= {30'h00000000, pin_s2_r[5], ~rst_q[7]};
            end
            `DRS_OFF_BOOT: begin
                reg_rdata <= {22'h000000, flash_fast_mode, boot_mode_valid,
                              boot_mode, boot_raw_r};
            end
            default: begin
                reg_rdata <= 32'h00000000;
            end
        endcase
    end else begin
        reg_rdata <= 32'h00000000;
    end
end

// ----------------------------------------
// boot sequencer
// ----------------------------------------
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_HOLD: begin
            if (!sys_active) begin
                state_nxt = ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (rst_q[3] && rst_q[6]) begin
                state_nxt = ST_SAMP;
            end
        end
        ST_SAMP: begin
            state_nxt = ST_DONE;
        end
        ST_DONE: begin
            state_nxt = ST_DONE;
        end
        default: begin
            state_nxt = ST_HOLD;
        end
    endcase
    if (sys_active) begin
        state_nxt = ST_HOLD;
    end
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        state_r <= ST_HOLD;
        boot_raw_r <= 4'h0;
        boot_mode <= `DRS_BOOT_FLASH;
        boot_mode_valid <= 1'b0;
        flash_fast_mode <= 1'b0;
    end else begin
        state_r <= state_nxt;
        if (state_r == ST_HOLD) begin
            boot_mode_valid <= 1'b0;
            flash_fast_mode <= 1'b0;
        end else if (state_r == ST_SAMP) begin
            // single capture; later pin changes are ignored
            boot_raw_r <= boot_pins_s;
            boot_mode <= boot_decode(boot_pins_s);
            boot_mode_valid <= 1'b1;
            flash_fast_mode <= (boot_decode(boot_pins_s) == `DRS_BOOT_FAST);
        end
    end
end

// ----------------------------------------
// control cpu idle
// ----------------------------------------
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        control_idle <= 1'b0;
    end else if (!rst_q[4]) begin
        control_idle <= 1'b0;
    end else if (master_to_control_wake_irq) begin
        control_idle <= 1'b0;
    end else if (control_init_done) begin
        control_idle <= 1'b1;
    end
end

endmodule // drs_seq

`default_nettype wire

// >>> tb/drs_ext_model.sv
// model of the board reset circuit and the boot strap pins
`timescale 1ns/10ps
`default_nettype none
module drs_ext_model (
    input wire logic clk,
    input wire logic pulse_req,
    input wire logic [3:0] strap,
    output wire logic external_reset_pin_n,
    output wire logic analog_reset_pin_n,
    output wire logic [3:0] boot_pins
);
    // remaining low cycles of the pin; starts low so power-up is covered
    logic [3:0] low_r = 4'ha;
    always @(posedge clk) begin
        if (pulse_req) begin
            low_r <= 4'h8;
        end else if (low_r != 4'h0) begin
            low_r <= low_r - 4'h1;
        end
    end
    assign external_reset_pin_n = (low_r == 4'h0);
    // the two reset pins are tied together on the board
    assign analog_reset_pin_n = external_reset_pin_n;
    assign boot_pins = strap;
endmodule // drs_ext_model
`default_nettype wire

// >>> tb/drs_seq_assertions.sv
// assertions on the ports of the reset sequencer
`timescale 1ns/10ps
`default_nettype none
module drs_seq_assertions (
    input wire clk,
    input wire resetn,
    input wire master_wdog0_timeout,
    input wire master_wdog1_timeout,
    input wire master_nmi_wdog_timeout,
    input wire control_nmi_watchdog_reset,
    input wire master_software_reset,
    input wire master_debugger_reset,
    input wire master_to_control_wake_irq,
    input wire master_system_reset_n,
    input wire master_cpu_reset_n,
    input wire external_parallel_port_reset_n,
    input wire control_cpu_reset_in_n,
    input wire control_system_reset_n,
    input wire shared_resource_reset_n,
    input wire analog_reset_n,
    input wire [31:0] master_periph_reset_n,
    input wire [3:0] boot_mode,
    input wire boot_mode_valid,
    input wire control_idle
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_sw_master: assert property ((master_software_reset || master_debugger_reset) |=>
        !master_system_reset_n) else $error("request did not reset master");
    chk_wdog_master: assert property ((master_wdog0_timeout || master_wdog1_timeout ||
        master_nmi_wdog_timeout) |=> !master_system_reset_n) else $error("watchdog missed");
    chk_cpu_hold: assert property (!master_system_reset_n |-> !master_cpu_reset_n)
        else $error("master cpu not in reset");
    chk_epi_hold: assert property (!master_system_reset_n |-> !external_parallel_port_reset_n)
        else $error("parallel port not in reset");
    chk_periph_hold: assert property (!master_system_reset_n |-> master_periph_reset_n == 32'h0)
        else $error("peripherals not in reset");
    chk_nmi_ctl: assert property (control_nmi_watchdog_reset |=> !control_cpu_reset_in_n)
        else $error("control nmi watchdog missed");
    chk_sys_follow: assert property ($fell(control_cpu_reset_in_n) |-> ##[0:2]
        !control_system_reset_n) else $error("control system reset late");
    chk_shared_analog: assert property (!shared_resource_reset_n |-> ##[0:1] !analog_reset_n)
        else $error("analog not reset by shared reset");
    chk_wake_idle: assert property (master_to_control_wake_irq |=> !control_idle)
        else $error("control stayed idle");
    chk_mode_stable: assert property ((boot_mode_valid && $past(boot_mode_valid)) |->
        boot_mode == $past(boot_mode)) else $error("boot mode moved");
    chk_mode_legal: assert property (boot_mode_valid |-> boot_mode inside
        {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'ha, 4'hf}) else $error("boot mode illegal");
endmodule // drs_seq_assertions

bind drs_seq drs_seq_assertions chk_u (.*);
`default_nettype wire

// >>> tb/dual_core_reset_boot_sequencer_test.sv
// self-checking bench of the reset sequencer
`timescale 1ns/10ps
`default_nettype none
module dual_core_reset_boot_sequencer_test;
    logic clk = 1'b0, resetn = 1'b0, pulse_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] ev = 8'h0, reg_addr = 8'h0;
    logic [3:0] strap = 4'h7;
    logic [31:0] reg_wdata = 32'h0, lf = 32'h6a63, d, dcf, prc;
    wire master_wdog0_timeout = ev[0], master_wdog1_timeout = ev[1],
        master_nmi_wdog_timeout = ev[2], master_debugger_reset = ev[3],
        master_software_reset = ev[4], control_nmi_watchdog_reset = ev[5],
        control_init_done = ev[6], master_to_control_wake_irq = ev[7];
    wire external_reset_pin_n, analog_reset_pin_n, master_system_reset_n, master_cpu_reset_n,
        external_parallel_port_reset_n, control_cpu_reset_in_n, control_system_reset_n,
        shared_resource_reset_n, analog_reset_n, analog_bus_reset_n, boot_mode_valid,
        flash_fast_mode, control_idle;
    wire [3:0] boot_pins, boot_mode;
    wire [31:0] reg_rdata, master_periph_reset_n;
    int n_fail = 0, checked = 0, i, c, k;

    initial begin
        forever #10 clk = ~clk;
    end

    drs_seq #(.OSC_MHZ(25)) dut_u (.*);
    drs_ext_model ext_u (.*);

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // oscillator of 25 MHz allows the fast flash code
    function automatic logic [3:0] exp_mode(input logic [3:0] code);
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'ha, 4'hf: return code;
            default: return 4'h7;
        endcase
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task tmo(input logic ok);
        chk(ok, 1'b1);
        if (ok !== 1'b1) finish_test;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // one-cycle event pulse; returns just after the edge that took it
    task pulse(input logic [7:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 8'h0;
        #1;
    endtask
    task wait_master;
        for (i = 0; i < 40 && master_system_reset_n !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        tmo(master_system_reset_n);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(control_cpu_reset_in_n, 1'b0);
        chk(analog_reset_n, 1'b0);
        rd(8'h10);
        chk(d, 32'h2);
        wr(8'h10, 32'h1f);
        rd(8'h10);
        chk(d, 32'h0);
        rd(8'h40);
        chk(d, 32'h0);
        $display("test power-on done");
        for (c = 0; c < 16; c++) begin
            strap <= c[3:0];
            if (c[0]) wr(8'h00, 32'h4);
            pulse(8'h10);
            chk(shared_resource_reset_n, !c[0]);
            wait_master;
            chk(boot_mode_valid, 1'b0);
            wr(8'h00, 32'h8);
            for (i = 0; i < 20 && boot_mode_valid !== 1'b1; i++) begin
                @(posedge clk);
                #1;
            end
            tmo(boot_mode_valid);
            chk(boot_mode, exp_mode(c[3:0]));
            chk(flash_fast_mode, c == 15);
            strap <= ~c[3:0];
            rd(8'h18);
            chk(d[9:0], {c == 15, 1'b1, exp_mode(c[3:0]), c[3:0]});
        end
        rd(8'h10);
        chk(d[4], 1'b1);
        $display("test boot modes done");
        wr(8'h00, 32'h9);
        // control system reset trails the control cpu reset by one edge
        repeat (2) @(posedge clk);
        rd(8'h04);
        chk(d[0], 1'b1);
        chk(control_cpu_reset_in_n, 1'b0);
        chk(control_system_reset_n, 1'b0);
        chk(master_system_reset_n, 1'b1);
        wr(8'h00, 32'ha);
        rd(8'h14);
        chk(d[1:0], 2'h3);
        chk(analog_bus_reset_n, 1'b0);
        chk(analog_reset_n, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk(control_cpu_reset_in_n, 1'b1);
        wr(8'h00, 32'h8);
        pulse(8'h20);
        chk(control_cpu_reset_in_n, 1'b0);
        chk(master_system_reset_n, 1'b1);
        repeat (4) @(posedge clk);
        pulse(8'h40);
        chk(control_idle, 1'b1);
        pulse(8'h80);
        chk(control_idle, 1'b0);
        $display("test selective resets done");
        for (k = 0; k < 8; k++) begin
            lf = lfsr_next(lf);
            pulse(8'h1 << lf[1:0]);
            chk(master_system_reset_n, 1'b0);
            chk(master_cpu_reset_n, 1'b0);
            chk(external_parallel_port_reset_n, 1'b0);
            chk(master_periph_reset_n, 32'h0);
            wait_master;
        end
        wr(8'h10, 32'h1f);
        pulse(8'h02);
        wait_master;
        rd(8'h10);
        chk(d[4:0], 5'h08);
        $display("test watchdog sources done");
        for (k = 0; k < 3; k++) begin
            lf = lfsr_next(lf);
            dcf = (k == 0) ? 32'h0 : lf;
            lf = lfsr_next(lf);
            prc = (k == 0) ? 32'hffffffff : lf;
            wr(8'h0c, dcf);
            wr(8'h08, prc);
            rd(8'h08);
            chk(d, prc);
            chk(master_periph_reset_n, ~(dcf & prc));
        end
        $display("test peripheral resets done");
        wr(8'h00, 32'h8);
        @(posedge clk);
        pulse_req <= 1'b1;
        @(posedge clk);
        pulse_req <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk(master_system_reset_n, 1'b0);
        chk(control_cpu_reset_in_n, 1'b0);
        chk(shared_resource_reset_n, 1'b0);
        wait_master;
        rd(8'h10);
        chk(d[0], 1'b1);
        $display("test reset pin done");
        finish_test;
    end
endmodule // dual_core_reset_boot_sequencer_test
`default_nettype wire
